/* File: pkg/smw_pkg.sv */
/*
 * Shared constants and types of the static memory access engine that handles
 * float wait cycles, external wait and the fixed slow-clock waveforms.
 * Assumes one master clock domain and one access in flight at a time.
 */
// Notes on behaviour
// - Float optimisation off: float wait cycles follow a read before the next access.
// - Hold of the controlling strobe already covering the float time adds no further float cycles.
// - Wait mode 10 frozen, 11 ready, 00 disabled and wait input ignored.
// - Wait acts on the strobe chosen by the read or write control mode.
// - Wait is sampled only in the pulse phase of the controlling strobe.
// - Frozen mode: asserted synced wait stops all counters and holds all outputs.
// - Frozen mode: on release the access resumes exactly where it stopped.
// - Ready mode: wait checked in last pulse cycle; held until release, then hold.
// - Ready mode: wait released early or raised late leaves access length unchanged.
// - Slow-clock indication replaces programmed timings by fixed waveforms on all selects.
// - Slow read: strobe setup 1 pulse 1, select setup 0 pulse 2, cycle 2.
// - Slow write: strobe setup 1 pulse 1, select setup 0 pulse 3, cycle 3.
// - A transfer running when slow mode ends finishes with the slow parameters.
// - Entering or leaving slow mode costs one reload wait cycle after the transfer.
// - The float count field gives 0 to 15 float wait cycles.
// - Float time starts at read strobe rise in mode 1, chip select rise in mode 0.

package smw_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int SETUP_W = 6;
    localparam int PULSE_W = 7;
    localparam int CYCLE_W = 9;
    localparam int FLOAT_W = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CS_NUM = 4;
    localparam int CS_W = 2;

    // ------------------------------------------------------------------
    // External wait mode encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] WAIT_OFF = 2'h0;
    localparam logic [1:0] WAIT_FROZEN = 2'h2;
    localparam logic [1:0] WAIT_READY = 2'h3;

    // ------------------------------------------------------------------
    // Fixed slow-clock waveforms, in master clock cycles
    // ------------------------------------------------------------------
    localparam logic [SETUP_W-1:0] SLOW_STROBE_SETUP = 6'h01;
    localparam logic [PULSE_W-1:0] SLOW_STROBE_PULSE = 7'h01;
    localparam logic [SETUP_W-1:0] SLOW_CS_SETUP = 6'h00;
    localparam logic [PULSE_W-1:0] SLOW_CS_RD_PULSE = 7'h02;
    localparam logic [PULSE_W-1:0] SLOW_CS_WR_PULSE = 7'h03;
    localparam logic [CYCLE_W-1:0] SLOW_RD_CYCLE = 9'h002;
    localparam logic [CYCLE_W-1:0] SLOW_WR_CYCLE = 9'h003;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CS_NUM-1:0] CS_IDLE_N = 4'hF;
    localparam logic [CYCLE_W-1:0] CNT_RESET = 9'h000;
    localparam logic WAIT_IDLE_N = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RELOAD,
        ST_ACCESS,
        ST_FLOAT
    } smw_state_type;

endpackage

/* File: rtl/smw_wait_sync.sv */
/*
 * Two-stage synchroniser for the active-low external wait input.
 * Assumes the wait pin is asynchronous to the master clock.
 */
`timescale 1ns/1ps
`default_nettype none

module smw_wait_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ext_wait_n,
    output logic wait_sync_n
);

    logic stage1_n;

    // Only the second stage is visible, so metastability stays inside.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_n <= smw_pkg::WAIT_IDLE_N;
            wait_sync_n <= smw_pkg::WAIT_IDLE_N;
        end else begin
            stage1_n <= ext_wait_n;
            wait_sync_n <= stage1_n;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/smw_static_mem_ctrl.sv */
/*
 * Access engine of the external static memory controller: strobe waveforms,
 * float wait cycles, external wait in frozen and ready modes, and the fixed
 * slow-clock waveforms. Assumes the requester presents the configuration of
 * the selected chip select together with each request.
 */
`timescale 1ns/1ps
`default_nettype none

module smw_static_mem_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [smw_pkg::CS_W-1:0] req_cs,
    input wire logic [smw_pkg::ADDR_W-1:0] req_addr,
    input wire logic [smw_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    input wire logic [smw_pkg::SETUP_W-1:0] rd_strobe_setup,
    input wire logic [smw_pkg::PULSE_W-1:0] rd_strobe_pulse,
    input wire logic [smw_pkg::CYCLE_W-1:0] rd_total_cycle,
    input wire logic [smw_pkg::SETUP_W-1:0] cs_rd_setup,
    input wire logic [smw_pkg::PULSE_W-1:0] cs_rd_pulse,
    input wire logic [smw_pkg::SETUP_W-1:0] wr_strobe_setup,
    input wire logic [smw_pkg::PULSE_W-1:0] wr_strobe_pulse,
    input wire logic [smw_pkg::CYCLE_W-1:0] wr_total_cycle,
    input wire logic [smw_pkg::SETUP_W-1:0] cs_wr_setup,
    input wire logic [smw_pkg::PULSE_W-1:0] cs_wr_pulse,
    input wire logic read_ctrl_mode,
    input wire logic write_ctrl_mode,
    input wire logic [1:0] ext_wait_mode_sel,
    input wire logic [smw_pkg::FLOAT_W-1:0] float_cycles,
    input wire logic float_opt_en,
    input wire logic slow_clock_req,
    input wire logic ext_wait_n,
    input wire logic [smw_pkg::DATA_W-1:0] mem_data_in,
    output logic [smw_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe,
    output logic [smw_pkg::ADDR_W-1:0] mem_addr,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [smw_pkg::CS_NUM-1:0] chip_select_n,
    output logic rsp_valid,
    output logic [smw_pkg::DATA_W-1:0] rsp_rdata,
    output logic access_stalled,
    output logic slow_mode_active,
    output logic reload_wait
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    smw_pkg::smw_state_type state;
    smw_pkg::smw_state_type next_state;
    logic [smw_pkg::CYCLE_W-1:0] cnt;
    logic [smw_pkg::FLOAT_W-1:0] float_cnt;
    logic slow_applied;
    logic a_write;
    logic [smw_pkg::CS_W-1:0] a_cs;
    logic [smw_pkg::SETUP_W-1:0] a_st_setup;
    logic [smw_pkg::PULSE_W-1:0] a_st_pulse;
    logic [smw_pkg::SETUP_W-1:0] a_cs_setup;
    logic [smw_pkg::PULSE_W-1:0] a_cs_pulse;
    logic [smw_pkg::CYCLE_W-1:0] a_cycle;
    logic a_ctl_strobe;
    logic [1:0] a_wait_mode;
    logic [smw_pkg::FLOAT_W-1:0] a_float;
    logic a_float_opt;
    logic [smw_pkg::DATA_W-1:0] a_wdata;
    logic wait_sync_n;
    logic wait_on;
    logic [smw_pkg::CYCLE_W-1:0] st_begin;
    logic [smw_pkg::CYCLE_W-1:0] st_end;
    logic [smw_pkg::CYCLE_W-1:0] sel_begin;
    logic [smw_pkg::CYCLE_W-1:0] sel_end;
    logic [smw_pkg::CYCLE_W-1:0] ctl_begin;
    logic [smw_pkg::CYCLE_W-1:0] ctl_end;
    logic [smw_pkg::CYCLE_W-1:0] cycle_eff;
    logic [smw_pkg::CYCLE_W-1:0] hold_len;
    logic [smw_pkg::FLOAT_W-1:0] float_extra;
    logic in_pulse;
    logic last_pulse;
    logic frozen;
    logic suspended;
    logic stall;
    logic access_end;
    logic accept;
    logic mode_change;
    logic st_low;
    logic sel_low;

    // ------------------------------------------------------------------
    // Wait input synchroniser
    // ------------------------------------------------------------------
    smw_wait_sync u_wait_sync (
        .clk(clk),
        .rst_b(rst_b),
        .ext_wait_n(ext_wait_n),
        .wait_sync_n(wait_sync_n)
    );

    assign wait_on = ~wait_sync_n;

    // ------------------------------------------------------------------
    // Request acceptance and slow-mode transitions
    // ------------------------------------------------------------------
    // A change of slow mode is only acted on in idle, so it always follows
    // the end of the transfer that was running when the change came.
    assign mode_change = (state == smw_pkg::ST_IDLE) && (slow_clock_req != slow_applied);
    assign req_ready = (state == smw_pkg::ST_IDLE) && !mode_change;
    assign accept = req_valid && req_ready;
    assign reload_wait = (state == smw_pkg::ST_RELOAD);
    assign slow_mode_active = slow_applied;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_applied <= 1'b0;
        end else if (state == smw_pkg::ST_RELOAD) begin
            slow_applied <= ~slow_applied;
        end
    end

    // ------------------------------------------------------------------
    // Per-access parameter set, latched when the request is taken
    // ------------------------------------------------------------------
    // Latching keeps a running transfer on the set it started with, which
    // is why a slow transfer finishes slow after the clock speeds up.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_write <= 1'b0;
            a_cs <= '0;
            a_st_setup <= '0;
            a_st_pulse <= '0;
            a_cs_setup <= '0;
            a_cs_pulse <= '0;
            a_cycle <= '0;
            a_ctl_strobe <= 1'b0;
            a_wait_mode <= smw_pkg::WAIT_OFF;
            a_float <= '0;
            a_float_opt <= 1'b0;
            a_wdata <= '0;
            mem_addr <= '0;
        end else if (accept) begin
            a_write <= req_write;
            a_cs <= req_cs;
            a_wdata <= req_wdata;
            mem_addr <= req_addr;
            a_ctl_strobe <= req_write ? write_ctrl_mode : read_ctrl_mode;
            if (slow_applied) begin
                a_st_setup <= smw_pkg::SLOW_STROBE_SETUP;
                a_st_pulse <= smw_pkg::SLOW_STROBE_PULSE;
                a_cs_setup <= smw_pkg::SLOW_CS_SETUP;
                a_cs_pulse <= req_write ? smw_pkg::SLOW_CS_WR_PULSE : smw_pkg::SLOW_CS_RD_PULSE;
                a_cycle <= req_write ? smw_pkg::SLOW_WR_CYCLE : smw_pkg::SLOW_RD_CYCLE;
                a_wait_mode <= smw_pkg::WAIT_OFF;
                a_float <= '0;
                a_float_opt <= 1'b0;
            end else begin
                a_st_setup <= req_write ? wr_strobe_setup : rd_strobe_setup;
                a_st_pulse <= req_write ? wr_strobe_pulse : rd_strobe_pulse;
                a_cs_setup <= req_write ? cs_wr_setup : cs_rd_setup;
                a_cs_pulse <= req_write ? cs_wr_pulse : cs_rd_pulse;
                a_cycle <= req_write ? wr_total_cycle : rd_total_cycle;
                a_wait_mode <= ext_wait_mode_sel;
                a_float <= float_cycles;
                a_float_opt <= float_opt_en;
            end
        end
    end

    // ------------------------------------------------------------------
    // Phase decode
    // ------------------------------------------------------------------
    assign st_begin = {3'h0, a_st_setup};
    assign st_end = {3'h0, a_st_setup} + {2'h0, a_st_pulse};
    assign sel_begin = {3'h0, a_cs_setup};
    assign sel_end = {3'h0, a_cs_setup} + {2'h0, a_cs_pulse};
    assign ctl_begin = a_ctl_strobe ? st_begin : sel_begin;
    assign ctl_end = a_ctl_strobe ? st_end : sel_end;
    assign cycle_eff = (a_cycle == smw_pkg::CNT_RESET) ? 9'h001 : a_cycle;

    assign in_pulse = (state == smw_pkg::ST_ACCESS) && (cnt >= ctl_begin) && (cnt < ctl_end);
    assign last_pulse = in_pulse && (cnt == ctl_end - 9'h001);

    // A disabled mode never looks at the wait input at all.
    assign frozen = (a_wait_mode == smw_pkg::WAIT_FROZEN) && in_pulse && wait_on;
    // Ready mode only looks in the final pulse cycle, so early releases
    // and late assertions leave the length untouched.
    assign suspended = (a_wait_mode == smw_pkg::WAIT_READY) && last_pulse && wait_on;
    assign stall = frozen || suspended;
    assign access_stalled = stall;

    assign access_end = (state == smw_pkg::ST_ACCESS) && !stall && (cnt + 9'h001 >= cycle_eff);

    // Float time runs from the rise of the controlling strobe; the hold part
    // of the cycle after that rise already counts toward it.
    assign hold_len = (cycle_eff > ctl_end) ? cycle_eff - ctl_end : 9'h000;
    assign float_extra = ({5'h00, a_float} > hold_len) ? a_float - hold_len[3:0] : 4'h0;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            smw_pkg::ST_IDLE: begin
                if (mode_change) begin
                    next_state = smw_pkg::ST_RELOAD;
                end else if (accept) begin
                    next_state = smw_pkg::ST_ACCESS;
                end
            end
            smw_pkg::ST_RELOAD: begin
                next_state = smw_pkg::ST_IDLE;
            end
            smw_pkg::ST_ACCESS: begin
                if (access_end) begin
                    if (!a_write && !a_float_opt && (float_extra != 4'h0)) begin
                        next_state = smw_pkg::ST_FLOAT;
                    end else begin
                        next_state = smw_pkg::ST_IDLE;
                    end
                end
            end
            smw_pkg::ST_FLOAT: begin
                if (float_cnt == 4'h1) begin
                    next_state = smw_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= smw_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase counter; a stall holds it so the access resumes in place.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= smw_pkg::CNT_RESET;
        end else if (accept) begin
            cnt <= smw_pkg::CNT_RESET;
        end else if (state == smw_pkg::ST_ACCESS && !stall) begin
            cnt <= cnt + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            float_cnt <= '0;
        end else if (access_end) begin
            float_cnt <= float_extra;
        end else if (state == smw_pkg::ST_FLOAT) begin
            float_cnt <= float_cnt - 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    // Strobes are registered from the counter, so they trail it by one
    // cycle; holding the counter freezes every pin at its present level.
    assign st_low = (state == smw_pkg::ST_ACCESS) && (cnt >= st_begin) && (cnt < st_end);
    assign sel_low = (state == smw_pkg::ST_ACCESS) && (cnt >= sel_begin) && (cnt < sel_end);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else begin
            read_strobe_n <= !(st_low && !a_write);
            write_strobe_n <= !(st_low && a_write);
        end
    end

    generate
        for (genvar i = 0; i < smw_pkg::CS_NUM; i++) begin : g_cs
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    chip_select_n[i] <= smw_pkg::CS_IDLE_N[i];
                end else begin
                    chip_select_n[i] <= !(sel_low && (a_cs == smw_pkg::CS_W'(i)));
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_data_out <= '0;
            mem_data_oe <= 1'b0;
        end else begin
            mem_data_out <= a_wdata;
            mem_data_oe <= (state == smw_pkg::ST_ACCESS) && a_write;
        end
    end

    // ------------------------------------------------------------------
    // Read response
    // ------------------------------------------------------------------
    // Data is taken in the last cycle of the controlling pulse that is not
    // stalled, just before the strobe rises.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_rdata <= '0;
        end else if (last_pulse && !stall && !a_write) begin
            rsp_rdata <= mem_data_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= access_end;
        end
    end

endmodule

`default_nettype wire

/* File: tb/smw_monitor.sv */
/*
 * Port checks of the access engine.
 * Assumes idle-only config changes and strobe-controlled wait.
 */
`timescale 1ns/1ps
`default_nettype none

module smw_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_ready,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [smw_pkg::CS_NUM-1:0] chip_select_n,
    input wire logic [1:0] ext_wait_mode_sel,
    input wire logic access_stalled,
    input wire logic slow_mode_active,
    input wire logic reload_wait
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_reload_single: assert property (reload_wait |=> !reload_wait)
        else $error("reload too long");
    a_reload_flip: assert property (reload_wait |=>
        slow_mode_active != $past(slow_mode_active))
        else $error("mode not flipped");
    a_stall_freeze: assert property (access_stalled |-> ##2
        ($stable(chip_select_n) && $stable(read_strobe_n) && $stable(write_strobe_n)))
        else $error("pins moved in stall");
    a_stall_pulse: assert property (access_stalled |=> !read_strobe_n || !write_strobe_n)
        else $error("stall outside pulse");
    a_stall_busy: assert property (access_stalled |-> !req_ready)
        else $error("ready while stalled");
    a_wait_ignored: assert property (!ext_wait_mode_sel[1] || slow_mode_active |->
        !access_stalled)
        else $error("stall, wait off");
    a_slow_read: assert property (slow_mode_active && $fell(read_strobe_n) |->
        chip_select_n != smw_pkg::CS_IDLE_N ##1
        (read_strobe_n && chip_select_n == smw_pkg::CS_IDLE_N))
        else $error("slow read wrong");
    a_slow_write: assert property (slow_mode_active && $fell(write_strobe_n) |=>
        (write_strobe_n && chip_select_n != smw_pkg::CS_IDLE_N) ##1
        chip_select_n == smw_pkg::CS_IDLE_N)
        else $error("slow write wrong");

    c_reload: cover property (reload_wait);
    c_frozen: cover property (access_stalled && ext_wait_mode_sel == smw_pkg::WAIT_FROZEN);
    c_ready: cover property (access_stalled && ext_wait_mode_sel == smw_pkg::WAIT_READY);
endmodule

`default_nettype wire

/* File: tb/smw_mem_model.sv */
/*
 * Memory model with an active-low wait answer.
 * Assumes wait delay and length change only between accesses.
 */
`timescale 1ns/1ps
`default_nettype none

module smw_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [smw_pkg::CS_NUM-1:0] chip_select_n,
    input wire logic mem_data_oe,
    input wire logic [smw_pkg::DATA_W-1:0] mem_data_out,
    input wire logic [smw_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [3:0] wait_delay,
    input wire logic [3:0] wait_len,
    output logic [smw_pkg::DATA_W-1:0] mem_data_in,
    output logic ext_wait_n,
    output logic [smw_pkg::DATA_W-1:0] last_wr
);
    logic [smw_pkg::DATA_W-1:0] junk;
    logic strobe_q;
    int k, nk;
    wire logic strobe_low = !read_strobe_n || !write_strobe_n;
    wire logic reading = chip_select_n != smw_pkg::CS_IDLE_N && write_strobe_n && !mem_data_oe;

    // A released bus toggles so stale data never matches.
    assign mem_data_in = reading ? (mem_addr[15:0] ^ 16'h5A3C) : junk;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            junk <= 16'hFFFF;
            strobe_q <= 1'b0;
            k <= 60;
            ext_wait_n <= 1'b1;
            last_wr <= 16'h0000;
        end else begin
            nk = (strobe_low && !strobe_q) ? 0 : ((k < 60) ? k + 1 : k);
            k <= nk;
            strobe_q <= strobe_low;
            junk <= ~junk;
            // One register plus two sync stages: the wait is seen four cycles into the pulse, so it fits a pulse of five or more.
            ext_wait_n <= !(nk >= wait_delay && nk < wait_delay + wait_len);
            if (!write_strobe_n && mem_data_oe) begin
                last_wr <= mem_data_out;
            end
        end
    end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Bench for the static memory access engine.
 * Assumes configuration changes only between accesses.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_cs = 2'h0;
    logic [23:0] req_addr = 24'h000000;
    logic [15:0] req_wdata = 16'h0000;
    logic [5:0] su = 6'h00;
    logic [5:0] csu = 6'h00;
    logic [6:0] pu = 7'h00;
    logic [6:0] cpu = 7'h00;
    logic [8:0] cy = 9'h000;
    logic [1:0] wmode = 2'h0;
    logic [3:0] fl = 4'h0;
    logic [3:0] wdel = 4'h0;
    logic [3:0] wlen = 4'h0;
    logic cmode = 1'b1;
    logic fopt = 1'b1;
    logic slow_req = 1'b0;
    logic clr = 1'b0;
    logic req_ready, mem_data_oe, read_strobe_n, write_strobe_n, rsp_valid;
    logic access_stalled, slow_mode_active, reload_wait, ext_wait_n;
    logic [15:0] mem_data_in, mem_data_out, rsp_rdata, last_wr;
    logic [23:0] mem_addr;
    logic [3:0] chip_select_n;
    int cs_len, st_len, stl, gap, last_gap, rl, g0, rl0, miscompares, cmp_count;
    int ft[6] = '{0,5,1,15,5,5};
    int fo[6] = '{0,0,0,0,0,1};
    int fc[6] = '{1,1,1,1,0,1};
    int fx[6] = '{0,4,0,14,3,0};
    int wm[6] = '{0,3,3,2,3,2};
    int wd[6] = '{0,0,0,0,4,4};
    int wl[6] = '{12,12,1,1,4,4};
    int we[6] = '{0,1,0,1,0,0};

    smw_static_mem_ctrl i_smw_static_mem_ctrl (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_cs(req_cs), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rd_strobe_setup(su),
        .rd_strobe_pulse(pu), .rd_total_cycle(cy), .cs_rd_setup(csu), .cs_rd_pulse(cpu),
        .wr_strobe_setup(su), .wr_strobe_pulse(pu), .wr_total_cycle(cy), .cs_wr_setup(csu),
        .cs_wr_pulse(cpu), .read_ctrl_mode(cmode), .write_ctrl_mode(cmode),
        .ext_wait_mode_sel(wmode), .float_cycles(fl), .float_opt_en(fopt),
        .slow_clock_req(slow_req), .ext_wait_n(ext_wait_n), .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_addr(mem_addr),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chip_select_n(chip_select_n), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .access_stalled(access_stalled), .slow_mode_active(slow_mode_active),
        .reload_wait(reload_wait));
    smw_mem_model i_smw_mem_model (.clk(clk), .rst_b(rst_b), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .chip_select_n(chip_select_n),
        .mem_data_oe(mem_data_oe), .mem_data_out(mem_data_out), .mem_addr(mem_addr),
        .wait_delay(wdel), .wait_len(wlen), .mem_data_in(mem_data_in),
        .ext_wait_n(ext_wait_n), .last_wr(last_wr));

    // ----------------------------------
    // Clock and pin measurement
    // ----------------------------------
    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (reload_wait === 1'b1) rl <= rl + 1;
        if (chip_select_n === smw_pkg::CS_IDLE_N) begin
            gap <= gap + 1;
        end else if (gap != 0) begin
            last_gap <= gap;
            gap <= 0;
        end
        if (clr) begin
            cs_len <= 0;
            st_len <= 0;
            stl <= 0;
        end else begin
            if (chip_select_n !== smw_pkg::CS_IDLE_N) cs_len <= cs_len + 1;
            if (read_strobe_n === 1'b0 || write_strobe_n === 1'b0) st_len <= st_len + 1;
            if (access_stalled === 1'b1) stl <= stl + 1;
        end
    end

    // ----------------------------------
    // Tasks
    // ----------------------------------
    task automatic summarize();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            miscompares++;
            $display("[ERR] %0t cnt %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t data %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cfg(input int p, c, cp, m, f, o, cm, d, l);
        @(posedge clk);
        su <= 6'h01;
        pu <= p[6:0];
        cy <= c[8:0];
        cpu <= cp[6:0];
        wmode <= m[1:0];
        fl <= f[3:0];
        fopt <= o[0];
        cmode <= cm[0];
        wdel <= d[3:0];
        wlen <= l[3:0];
    endtask

    // A hang counts as a mismatch.
    task automatic give_up(input int n, input int lim);
        if (n >= lim) begin
            miscompares++;
            summarize();
        end
    endtask

    task automatic do_req(input logic wr, input logic [1:0] cs, input logic [23:0] a,
            input logic [15:0] d);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_cs <= cs;
        req_addr <= a;
        req_wdata <= d;
        clr <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        clr <= 1'b0;
        give_up(n, 200);
    endtask

    task automatic wait_for(input int which, input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((which == 0 ? rsp_valid : slow_mode_active) !== v && n < 300);
        give_up(n, 300);
        #1;
    endtask

    task automatic acc(input logic wr, input logic [1:0] cs, input logic [23:0] a,
            input logic [15:0] d);
        do_req(wr, cs, a, d);
        req_valid <= 1'b0;
        wait_for(0, 1'b1);
        chk_word(wr ? last_wr : rsp_rdata, wr ? d : (a[15:0] ^ 16'h5A3C));
    endtask

    // ----------------------------------
    // Sequence
    // ----------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            cfg(2, 4, 2, 0, ft[i], fo[i], fc[i], 0, 0);
            do_req(1'b0, 2'h1, 24'h000100, 16'h0000);
            acc(1'b0, 2'h1, 24'h000200, 16'h0000);
            if (i == 0) g0 = last_gap;
            else chk_cnt(last_gap - g0, fx[i]);
        end
        for (int op = 0; op < 2; op++) begin
            for (int i = 0; i < 6; i++) begin
                // Hold 2, pulse 7: room for the wait.
                cfg(7, 10, 10, wm[i], 0, 1, 1, wd[i], wl[i]);
                acc(op[0], 2'h2, 24'h00A55A, 16'hC35A);
                chk_cnt(int'(stl > 0), we[i]);
                chk_cnt(cs_len, 10 + stl);
                chk_cnt(st_len, 7 + stl);
            end
        end
        cfg(7, 10, 10, 0, 0, 1, 1, 0, 0);
        rl0 = rl;
        slow_req <= 1'b1;
        wait_for(1, 1'b1);
        chk_cnt(rl - rl0, 1);
        for (int op = 0; op < 2; op++) begin
            acc(op[0], 2'h3, 24'h000042, 16'h1234);
            chk_cnt(cs_len, 2 + op);
            chk_cnt(st_len, 1);
        end
        rl0 = rl;
        do_req(1'b1, 2'h0, 24'h000077, 16'hBEEF);
        req_valid <= 1'b0;
        slow_req <= 1'b0;
        wait_for(0, 1'b1);
        chk_cnt(cs_len, 3);
        wait_for(1, 1'b0);
        chk_cnt(rl - rl0, 1);
        acc(1'b0, 2'h0, 24'h000077, 16'h0000);
        chk_cnt(cs_len, 10);
        summarize();
    end
endmodule

bind smw_static_mem_ctrl smw_monitor i_smw_monitor (.clk(clk), .rst_b(rst_b),
    .req_ready(req_ready), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chip_select_n(chip_select_n), .ext_wait_mode_sel(ext_wait_mode_sel),
    .access_stalled(access_stalled), .slow_mode_active(slow_mode_active),
    .reload_wait(reload_wait));

`default_nettype wire
